// ===== core/cpsc_pkg.sv
// Package of constants, types and helpers for the clock prescaler.
`default_nettype none

package cpsc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map and fields.
  localparam logic [31:0] CPSC_CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] CPSC_STATUS_OFFSET = 32'h0000_0004;
  localparam int CPSC_UNLOCK_BIT = 7;
  localparam int CPSC_SELECT_MSB = 3;
  localparam int CPSC_PENDING_BIT = 0;
  localparam int CPSC_RC_BIT = 1;
  localparam int CPSC_BLOCK_BIT = 2;
  localparam int CPSC_ACTIVE_LSB = 4;
  localparam logic [3:0] CPSC_SELECT_RESET_PLAIN = 4'h0;
  localparam logic [3:0] CPSC_SELECT_RESET_DIV8 = 4'h3;
  localparam logic [3:0] CPSC_CODE_MAX_POW = 4'h8;
  localparam logic [3:0] CPSC_CODE_RC_ONLY = 4'hf;
  localparam logic [2:0] CPSC_UNLOCK_CYCLES = 3'h4;
  localparam logic [1:0] CPSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPSC_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite request and response bundles.
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } cpsc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } cpsc_axi_rsp_t;

  ////////////////////////////////////////////////////////////////////////
  // Log2 of the division factor for a code and source.
  function automatic logic [3:0] cpsc_div_exp(input logic [3:0] code,
                                              input logic rc);
    logic [3:0] base;
    base = code;
    // Reserved codes are clamped to the slowest legal rate, which is
    // the safe side if software ever stores one.
    if (code == CPSC_CODE_RC_ONLY) begin
      base = 4'h0;
    end else if (code > CPSC_CODE_MAX_POW) begin
      base = CPSC_CODE_MAX_POW;
    end
    if (rc && code != CPSC_CODE_RC_ONLY) begin
      cpsc_div_exp = base + 4'h1;
    end else begin
      cpsc_div_exp = base;
    end
  endfunction

  // Terminal count of the divider for a factor of two to the exp.
  function automatic logic [8:0] cpsc_term(input logic [3:0] exp);
    logic [9:0] full;
    full = 10'h1 << exp;
    cpsc_term = 9'(full - 10'h1);
  endfunction

endpackage

`default_nettype wire

// ===== core/cpsc_sync.sv
// Two-flop synchroniser for pin-level inputs.
`default_nettype none

module cpsc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and enable.
  input wire logic clk_in,
  input wire logic ce_in,
  // Data.
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second; it is not reset so that a
  // strap is already settled when reset is released.
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// ===== core/cpsc_divider.sv
// Glitch-free divider that issues the divided system clock enable.
`default_nettype none

module cpsc_divider
  import cpsc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control.
  input wire logic [3:0] rst_exp_in,
  input wire logic load_in,
  input wire logic [3:0] load_exp_in,
  // State.
  output logic tick_out,
  output logic pending_out,
  output logic [3:0] exp_out
);

  logic [8:0] count;
  logic [3:0] pend_exp;
  logic at_end;

  assign at_end = (count == cpsc_term(exp_out));

  // A new factor waits for the end of the running period, so the old
  // period completes and the first new one starts from zero.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count <= 9'h000;
      tick_out <= 1'b0;
      exp_out <= rst_exp_in;
      pend_exp <= 4'h0;
      pending_out <= 1'b0;
    end else if (ce_in) begin
      tick_out <= at_end;
      if (at_end) begin
        count <= 9'h000;
        if (pending_out && !load_in) begin
          exp_out <= pend_exp;
          pending_out <= 1'b0;
        end
      end else begin
        count <= count + 9'h001;
      end
      if (load_in) begin
        pend_exp <= load_exp_in;
        pending_out <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== core/cpsc_top.sv
// Clock prescaler top: AXI4-Lite registers, unlock window, divider.
`default_nettype none

module cpsc_top (
  // Master clock, reset and enable.
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Straps and source indication from pins.
  input wire logic DIVIDE_BY_EIGHT_FUSE_IN,
  input wire logic OSC_IS_RC_IN,
  // Register bus.
  input wire cpsc_pkg::cpsc_axi_req_t AXI_REQ_IN,
  output cpsc_pkg::cpsc_axi_rsp_t AXI_RSP_OUT,
  // Divided system clock enable and programming inhibit.
  output logic SYS_CLK_EN_OUT,
  output logic PROG_BLOCK_OUT
);
  import cpsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths so that the two
  // can never disagree about which offsets are mapped.
  function automatic logic is_ctrl(input logic [31:0] addr);
    is_ctrl = (addr == CPSC_CTRL_OFFSET);
  endfunction

  function automatic logic is_status(input logic [31:0] addr);
    is_status = (addr == CPSC_STATUS_OFFSET);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The fuse strap and the source flag come from
  // outside this clock domain, so nothing reads them before two flops;
  // the cost is two cycles of lag on a source change.
  logic [1:0] pins_s;
  logic fuse_s;
  logic rc_s;

  cpsc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(CORE_CLK_IN),
    .ce_in(CE_IN),
    .d_in({DIVIDE_BY_EIGHT_FUSE_IN, OSC_IS_RC_IN}),
    .q_out(pins_s)
  );

  // Bit 1 is the fuse strap, bit 0 the source flag.
  assign fuse_s = pins_s[1];
  assign rc_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // Bus slave state. Each channel keeps its own flags so the write
  // address and data may arrive in either order.
  logic aw_rdy;
  logic w_rdy;
  logic aw_got;
  logic w_got;
  logic [31:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic bvalid;
  logic [1:0] bresp;
  logic ar_rdy;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [31:0] read_word;
  logic read_err;

  // Handshake strobes and the next values of the channel state.
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  logic next_rvalid;
  logic next_aw_rdy;
  logic next_w_rdy;
  logic next_ar_rdy;

  assign aw_hs = AXI_REQ_IN.awvalid & aw_rdy;
  assign w_hs = AXI_REQ_IN.wvalid & w_rdy;
  assign ar_hs = AXI_REQ_IN.arvalid & ar_rdy;
  // Writes act once both halves are held, which costs a cycle but
  // keeps one path for either arrival order.
  assign do_write = aw_got & w_got & ~bvalid;
  assign next_aw_got = aw_hs | (aw_got & ~do_write);
  assign next_w_got = w_hs | (w_got & ~do_write);
  assign next_bvalid = do_write | (bvalid & ~AXI_REQ_IN.bready);
  assign next_rvalid = ar_hs | (rvalid & ~AXI_REQ_IN.rready);
  // A ready drops as soon as its half is held or a response is owed,
  // so a second write is never taken before the first is answered.
  assign next_aw_rdy = ~next_aw_got & ~next_bvalid;
  assign next_w_rdy = ~next_w_got & ~next_bvalid;
  assign next_ar_rdy = ~next_rvalid;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler control state. The selection only moves through the
  // unlock window, so a stray write cannot change the system rate.
  logic prescale_change_unlock;
  logic [2:0] unlock_count;
  logic [3:0] prescale_select;
  logic ctrl_hit;
  logic wr_ctrl;
  logic unlock_write;
  logic select_write;
  logic div_load;
  logic div_tick;
  logic div_pending;
  logic [3:0] div_exp;
  logic [3:0] rst_exp;

  // Decode of the write that is about to act.
  assign ctrl_hit = is_ctrl(aw_addr);
  assign wr_ctrl = do_write & ctrl_hit & w_lane;
  // Only the exact pattern with every other bit zero sets the flag.
  assign unlock_write = wr_ctrl && w_byte[CPSC_UNLOCK_BIT]
                        && (w_byte[CPSC_UNLOCK_BIT-1:0] == 7'h00);
  assign select_write = wr_ctrl & ~unlock_write;
  assign div_load = select_write & prescale_change_unlock;
  // Reset factor, from the synced fuse and source flags.
  assign rst_exp = cpsc_div_exp(fuse_s ? CPSC_SELECT_RESET_DIV8
                                       : CPSC_SELECT_RESET_PLAIN, rc_s);

  ////////////////////////////////////////////////////////////////////////
  // Write address channel. The address is held until the write acts,
  // so a late data beat still lands on the right register.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      aw_got <= 1'b0;
      aw_rdy <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (CE_IN) begin
      aw_got <= next_aw_got;
      aw_rdy <= next_aw_rdy;
      if (aw_hs) begin
        aw_addr <= AXI_REQ_IN.awaddr;
      end
    end
  end

  // Write data channel; only byte lane 0 carries the register, and a
  // write without that lane is answered but changes nothing.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      w_got <= 1'b0;
      w_rdy <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (CE_IN) begin
      w_got <= next_w_got;
      w_rdy <= next_w_rdy;
      if (w_hs) begin
        w_byte <= AXI_REQ_IN.wdata[7:0];
        w_lane <= AXI_REQ_IN.wstrb[0];
      end
    end
  end

  // Write response; the status register is read-only but answers OKAY.
  // An unmapped offset is refused so a wrong pointer shows up early.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      bvalid <= 1'b0;
      bresp <= CPSC_RESP_OKAY;
    end else if (CE_IN) begin
      bvalid <= next_bvalid;
      if (do_write) begin
        if (ctrl_hit || is_status(aw_addr)) begin
          bresp <= CPSC_RESP_OKAY;
        end else begin
          bresp <= CPSC_RESP_SLVERR;
        end
      end
    end
  end

  // Read word, decoded from the address as offered; it is captured only
  // on the handshake edge, so the held data cannot drift afterwards.
  always_comb begin
    read_word = 32'h0000_0000;
    read_err = 1'b0;
    if (is_ctrl(AXI_REQ_IN.araddr)) begin
      read_word[CPSC_UNLOCK_BIT] = prescale_change_unlock;
      read_word[CPSC_SELECT_MSB:0] = prescale_select;
    end else if (is_status(AXI_REQ_IN.araddr)) begin
      read_word[CPSC_PENDING_BIT] = div_pending;
      read_word[CPSC_RC_BIT] = rc_s;
      read_word[CPSC_BLOCK_BIT] = PROG_BLOCK_OUT;
      read_word[CPSC_ACTIVE_LSB+3:CPSC_ACTIVE_LSB] = div_exp;
    end else begin
      read_err = 1'b1;
    end
  end

  // Read channel with registered data.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      rvalid <= 1'b0;
      ar_rdy <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= CPSC_RESP_OKAY;
    end else if (CE_IN) begin
      rvalid <= next_rvalid;
      ar_rdy <= next_ar_rdy;
      if (ar_hs) begin
        rdata <= read_word;
        rresp <= read_err ? CPSC_RESP_SLVERR : CPSC_RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock window: opened by the exact pattern, closed after the count
  // or by the selection write that it permits. The count is never
  // reloaded while open, which is what stops a looping unlock write
  // from holding the window open for ever.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      prescale_change_unlock <= 1'b0;
      unlock_count <= 3'h0;
    end else if (CE_IN) begin
      if (select_write && prescale_change_unlock) begin
        prescale_change_unlock <= 1'b0;
        unlock_count <= 3'h0;
      end else if (unlock_write && !prescale_change_unlock) begin
        prescale_change_unlock <= 1'b1;
        unlock_count <= CPSC_UNLOCK_CYCLES;
      end else if (prescale_change_unlock) begin
        // A repeated unlock write lands here: the count runs on.
        if (unlock_count == 3'h1) begin
          prescale_change_unlock <= 1'b0;
        end
        unlock_count <= unlock_count - 3'h1;
      end
    end
  end

  // Selection field: loaded from the fuse at reset, then only through
  // the unlock window. The fuse flops settle while reset is held.
  // Reserved codes are stored as written; the divider clamps them.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      prescale_select <= fuse_s ? CPSC_SELECT_RESET_DIV8
                                : CPSC_SELECT_RESET_PLAIN;
    end else if (CE_IN) begin
      if (div_load) begin
        // Every code is stored as written, fuse or not.
        prescale_select <= w_byte[CPSC_SELECT_MSB:0];
      end
      // A locked write falls through and keeps the setting.
    end
  end

  // Programming inhibit while the divide-by-one RC code is stored.
  // It follows the stored code one cycle late, not the running rate.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      PROG_BLOCK_OUT <= 1'b0;
    end else if (CE_IN) begin
      PROG_BLOCK_OUT <= (prescale_select == CPSC_CODE_RC_ONLY);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider. The source flag is sampled when a setting is loaded; a
  // source change alone does not re-time the running factor, so
  // software that moves the source writes the selection again.
  cpsc_divider u_div (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .rst_exp_in(rst_exp),
    .load_in(div_load),
    .load_exp_in(cpsc_div_exp(w_byte[CPSC_SELECT_MSB:0], rc_s)),
    .tick_out(div_tick),
    .pending_out(div_pending),
    .exp_out(div_exp)
  );

  // Every synchronous consumer takes this one enable, so all of them
  // slow down together; gating the clock itself would add skew.
  assign SYS_CLK_EN_OUT = div_tick;

  // Bus outputs, each field from its own flop, packed in one place so
  // that the whole response has a single driver.
  assign AXI_RSP_OUT = '{
    awready: aw_rdy,
    wready: w_rdy,
    bresp: bresp,
    bvalid: bvalid,
    arready: ar_rdy,
    rdata: rdata,
    rresp: rresp,
    rvalid: rvalid
  };

endmodule

`default_nettype wire

// ===== sim/cpsc_properties.sv
// Port-level concurrent checks for the clock prescaler.
`default_nettype none

module cpsc_properties (
  // Clock, reset and enable.
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Straps.
  input wire logic DIVIDE_BY_EIGHT_FUSE_IN,
  input wire logic OSC_IS_RC_IN,
  // Register bus.
  input wire cpsc_pkg::cpsc_axi_req_t AXI_REQ_IN,
  input wire cpsc_pkg::cpsc_axi_rsp_t AXI_RSP_OUT,
  // Outputs.
  input wire logic SYS_CLK_EN_OUT,
  input wire logic PROG_BLOCK_OUT
);
  import cpsc_pkg::*;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  //////////////////////////////////////////////////////////////////////
  // Handshake shorthands; the bench keeps CE_IN high throughout.
  logic aw_hs, w_hs, ar_hs;
  assign aw_hs = AXI_REQ_IN.awvalid && AXI_RSP_OUT.awready;
  assign w_hs = AXI_REQ_IN.wvalid && AXI_RSP_OUT.wready;
  assign ar_hs = AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready;
  sequence both_taken;
    aw_hs && w_hs;
  endsequence
  sequence resp_due;
    ##2 AXI_RSP_OUT.bvalid;
  endsequence

  //////////////////////////////////////////////////////////////////////
  // Reset quietens every output, so reset is not a disable here.
  reset_quiet_a: assert property (disable iff (1'b0)
    (!RST_N_IN && CE_IN) |=> (!SYS_CLK_EN_OUT && !PROG_BLOCK_OUT &&
    !AXI_RSP_OUT.bvalid && !AXI_RSP_OUT.rvalid))
    else $error("outputs active during reset");
  write_answer_a: assert property (both_taken |-> resp_due)
    else $error("write response late");
  read_answer_a: assert property (ar_hs |=> AXI_RSP_OUT.rvalid)
    else $error("read response late");
  read_hold_a: assert property (
    AXI_RSP_OUT.rvalid && !AXI_REQ_IN.rready |=>
    AXI_RSP_OUT.rvalid && $stable(AXI_RSP_OUT.rdata))
    else $error("read data dropped early");
  write_block_a: assert property (
    AXI_RSP_OUT.bvalid |-> !AXI_RSP_OUT.awready && !AXI_RSP_OUT.wready)
    else $error("write taken while response pending");
  read_block_a: assert property (
    AXI_RSP_OUT.rvalid |-> !AXI_RSP_OUT.arready)
    else $error("read taken while data pending");
  unmapped_err_a: assert property (ar_hs &&
    AXI_REQ_IN.araddr != CPSC_CTRL_OFFSET &&
    AXI_REQ_IN.araddr != CPSC_STATUS_OFFSET |=>
    AXI_RSP_OUT.rresp == CPSC_RESP_SLVERR && AXI_RSP_OUT.rdata == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (
    AXI_RSP_OUT.rvalid |-> AXI_RSP_OUT.rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  block_cause_a: assert property (
    $rose(PROG_BLOCK_OUT) |-> $past(AXI_RSP_OUT.bvalid))
    else $error("inhibit rose without a write");
endmodule

bind cpsc_top cpsc_properties u_props (.CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
  .DIVIDE_BY_EIGHT_FUSE_IN(DIVIDE_BY_EIGHT_FUSE_IN),
  .OSC_IS_RC_IN(OSC_IS_RC_IN), .AXI_REQ_IN(AXI_REQ_IN),
  .AXI_RSP_OUT(AXI_RSP_OUT), .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT),
  .PROG_BLOCK_OUT(PROG_BLOCK_OUT));

`default_nettype wire

// ===== sim/cpsc_top_tb.sv
// Self-checking bench for the clock prescaler.
`default_nettype none

module cpsc_top_tb;
  import cpsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, fuse, rc, tick, block, bv_prev;
  cpsc_axi_req_t req;
  cpsc_axi_rsp_t rsp;
  int mismatches, check_count, sel, cnt, old, msrc, i, k, code;
  integer seed;
  logic [31:0] d;
  logic [1:0] r, br;

  cpsc_top uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
    .DIVIDE_BY_EIGHT_FUSE_IN(fuse), .OSC_IS_RC_IN(rc), .AXI_REQ_IN(req),
    .AXI_RSP_OUT(rsp), .SYS_CLK_EN_OUT(tick), .PROG_BLOCK_OUT(block));

  // Master clock, 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////
  // Reference model, updated from the write edge seen on bvalid.
  always @(negedge clk) begin
    if (!rst_n) begin
      sel = fuse ? 3 : 0;
      cnt = 0;
      msrc = rc;
    end else begin
      old = cnt;
      if (cnt > 0) cnt--;
      if (rsp.bvalid && !bv_prev && req.awaddr === CPSC_CTRL_OFFSET) begin
        if (req.wdata[7:0] === 8'h80) begin
          if (old == 0) cnt = 4;
        end else if (old > 0) begin
          sel = req.wdata[3:0];
          msrc = rc;
          cnt = 0;
        end
      end
    end
    bv_prev = rsp.bvalid;
  end

  // Log2 of the expected division factor.
  function automatic int fexp(input int c, input int s);
    if (c == 15) return 0;
    return (c > 8 ? 8 : c) + s;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Comparison, reporting and closing helpers.
  task chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task chk_gap(input int e, input int g);
    check_count++;
    if (g != e) begin
      mismatches++;
      $display("MISMATCH tick_gap expected %0d seen %0d", e, g);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task fail_out(input string what);
    mismatches++;
    $display("MISMATCH %s expected done seen timeout", what);
    end_of_test();
  endtask

  //////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, bready held up.
  task wr(input logic [31:0] a, input logic [7:0] v);
    int n;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (n == 50) fail_out("write");
    br = rsp.bresp;
  endtask
  // Read; rready comes a cycle late so the slave must hold its data.
  task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] e);
    int n;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid) break;
      req.rready <= rsp.rvalid;
    end
    v = rsp.rdata;
    e = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 50) fail_out("read");
  endtask

  // Cycles between two divided clock pulses.
  task gap(output int g);
    int n;
    for (n = 0; n < 1100; n++) begin
      @(negedge clk);
      if (tick) break;
    end
    for (g = 1; g < 1100; g++) begin
      @(negedge clk);
      if (tick) break;
    end
    if (n == 1100 || g == 1100) fail_out("tick");
  endtask

  // Compare control, settle, then compare rate, status and inhibit.
  task verify;
    int g;
    rd(CPSC_CTRL_OFFSET, d, r);
    chk_val("ctrl", {28'h0, 4'(sel)}, d);
    gap(g);
    gap(g);
    gap(g);
    chk_gap(1 << fexp(sel, msrc), g);
    rd(CPSC_STATUS_OFFSET, d, r);
    chk_val("status", {24'h0, 4'(fexp(sel, msrc)), 1'b0, 1'(sel == 15),
      rc, 1'b0}, d);
    chk_val("inhibit", {31'h0, 1'(sel == 15)}, {31'h0, block});
    $display("test done select %0d", sel);
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 71;
    req = '0;
    rst_n = 1'b0;
    fuse = 1'b1;
    rc = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    verify();
    wr(CPSC_CTRL_OFFSET, 8'h05);
    chk_val("ctrl_wresp", {30'h0, CPSC_RESP_OKAY}, {30'h0, br});
    verify();
    wr(CPSC_CTRL_OFFSET, 8'h80);
    wr(CPSC_CTRL_OFFSET, 8'h80);
    wr(CPSC_CTRL_OFFSET, 8'h01);
    verify();
    wr(CPSC_CTRL_OFFSET, 8'h81);
    wr(CPSC_CTRL_OFFSET, 8'h02);
    wr(CPSC_STATUS_OFFSET, 8'hff);
    chk_val("status_wresp", {30'h0, CPSC_RESP_OKAY}, {30'h0, br});
    wr(32'h0000_0008, 8'h00);
    chk_val("unmapped_wresp", {30'h0, CPSC_RESP_SLVERR}, {30'h0, br});
    verify();
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      // The divide-by-one code keeps the RC source while it is stored.
      rc <= (sel == 15) ? 1'b1 : 1'($random(seed));
      repeat (4) @(posedge clk);
      k = {$random(seed)} % 4;
      if (k != 3) wr(CPSC_CTRL_OFFSET, 8'h80);
      repeat (k) @(posedge clk);
      code = {$random(seed)} % 10;
      if (code == 9) code = rc ? 15 : 8;
      wr(CPSC_CTRL_OFFSET, 8'(code));
      verify();
    end
    rd(32'h0000_0008, d, r);
    chk_val("unmapped_resp", {30'h0, CPSC_RESP_SLVERR}, {30'h0, r});
    chk_val("unmapped_data", 32'h0, d);
    fuse <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    verify();
    end_of_test();
  end
endmodule

`default_nettype wire
